//--- core/iss_pkg.sv
package iss_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
  localparam longint WARN_MINUTES = 30;
  localparam logic [34:0] WARN_CYCLES = 35'(WARN_MINUTES * 60 * CLK_HZ);
  localparam int FLASH_SLOTS = 20;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  localparam int CTRL_VARIANT = 0;
  localparam logic CTRL_VARIANT_RESET = 1'b0;
  localparam logic [4:0] IRQ_EN_RESET = 5'h00;
  localparam int IRQ_W = 5;
  localparam int IRQ_WARN = 0;
  localparam int IRQ_SHUT = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_FORCED = 3;
  localparam int IRQ_LOCKOUT = 4;
  localparam int ST_CODE_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    CODE_NONE = 4'h0, CODE_OUT_A = 4'h1, CODE_OUT_B = 4'h2,
    CODE_CROSS = 4'h3, CODE_TEMP = 4'h4, CODE_ACTUATOR = 4'h5,
    CODE_INTERNAL = 4'h6, CODE_LOCK_MECH = 4'h7, CODE_VOLT = 4'h8
  } iss_code_t;
  typedef enum logic [1:0] {
    GUARD_OPEN = 2'b00, GUARD_CLOSED = 2'b01, GUARD_LOCKED = 2'b10
  } iss_guard_t;
  typedef struct packed {
    logic lockCmd;
    logic safetyInA;
    logic safetyInB;
    logic actuatorOk;
    logic guardClosed;
    logic lockEngaged;
    logic forcedOpen;
    logic faultOutA;
    logic faultOutB;
    logic crossShort;
    logic overTemp;
    logic voltFault;
    logic actuatorFault;
    logic internalErr;
    logic lockMechErr;
    logic deviceDefect;
  } iss_pins_t;
  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } iss_led_t;
endpackage : iss_pkg

//--- core/iss_sync.sv
`timescale 1ns/1ps
module iss_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // level crossing
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // stage1 is read by syncOut only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule : iss_sync

//--- core/iss_flasher.sv
`timescale 1ns/1ps
module iss_flasher
  import iss_pkg::*;
#(
  parameter int HALF_CYCLES = BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // code to show
  input iss_code_t code,
  // patterns
  output logic blink,
  output logic pulse
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  if (HALF_CYCLES < 2) begin : g_chk
    $error("flasher half period too short");
  end

  logic [CW-1:0] tickCnt;
  logic [CW-1:0] next_tickCnt;
  logic [4:0] slot;
  logic [4:0] next_slot;
  logic next_blink;
  logic next_pulse;
  logic tick;

  // pulses sit on even half periods, a pause fills the frame tail
  always_comb begin
    tick = tickCnt == CW'(HALF_CYCLES - 1);
    next_tickCnt = tick ? '0 : tickCnt + 1'b1;
    next_blink = tick ? ~blink : blink;
    next_slot = slot;
    if (tick) begin
      next_slot = (slot == 5'(FLASH_SLOTS - 1)) ? 5'h0 : slot + 5'h1;
    end
    next_pulse = (code != CODE_NONE) && !slot[0] && (slot[4:1] < code);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tickCnt <= '0;
      slot <= 5'h0;
      blink <= 1'b0;
      pulse <= 1'b0;
    end else begin
      tickCnt <= next_tickCnt;
      slot <= next_slot;
      blink <= next_blink;
      pulse <= next_pulse;
    end
  end
endmodule : iss_flasher

//--- core/iss_top.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module iss_top
  import iss_pkg::*;
#(
  parameter logic [34:0] WARN_LIMIT = WARN_CYCLES,
  parameter int HALF_CYCLES = BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // device pins
  input iss_pins_t pins,
  output logic lockEngage,
  output logic safety_output_a,
  output logic safety_output_b,
  output logic diagOut,
  output iss_led_t leds,
  output logic irq,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  if (WARN_LIMIT < 35'd2) begin : g_chk
    $error("warning limit too short");
  end

  // ==========================================================
  // pin synchronisers and flash patterns
  iss_pins_t sIn;
  logic blink;
  logic pulse;
  iss_code_t code;

  iss_sync #(.WIDTH($bits(iss_pins_t))) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncIn(pins),
    .syncOut(sIn)
  );

  iss_flasher #(.HALF_CYCLES(HALF_CYCLES)) u_flash (
    .sys_clk(sys_clk),
    .reset(reset),
    .code(code),
    .blink(blink),
    .pulse(pulse)
  );

  // ==========================================================
  // supervisor state
  logic variant;
  logic warnActive, shutLatch, errLatch, lockout, forced;
  logic [34:0] warnCnt;
  iss_code_t next_code, curCode;
  logic next_warnActive, next_shutLatch, next_errLatch;
  logic next_lockout, next_forced, next_lockEngage;
  logic [34:0] next_warnCnt;
  logic next_outA, next_outB, next_diag;
  iss_led_t next_leds;
  iss_guard_t guard;
  logic warnNow, errNow, lockoutNow, bothIn, enBase, canEnable;
  logic enabled, warnExpire;

  always_comb begin
    warnNow = sIn.faultOutA | sIn.faultOutB | sIn.crossShort |
              sIn.overTemp | sIn.voltFault;
    errNow = sIn.actuatorFault | sIn.internalErr | sIn.lockMechErr |
             sIn.deviceDefect;
    lockoutNow = (sIn.faultOutA & sIn.faultOutB) | sIn.crossShort;
    bothIn = sIn.safetyInA & sIn.safetyInB;
    if (!sIn.guardClosed) begin
      guard = GUARD_OPEN;
    end else if (sIn.lockEngaged) begin
      guard = GUARD_LOCKED;
    end else begin
      guard = GUARD_CLOSED;
    end
    next_lockEngage = !sIn.lockCmd && sIn.actuatorOk;
    // variant 0 needs the bolt, variant 1 only a closed guard
    if (variant) begin
      enBase = sIn.guardClosed && sIn.actuatorOk;
    end else begin
      enBase = guard == GUARD_LOCKED && sIn.actuatorOk;
    end
    canEnable = enBase && !shutLatch && !errLatch && !errNow &&
                !lockout && !forced && !sIn.forcedOpen;
    next_outA = canEnable && sIn.safetyInA;
    next_outB = canEnable && sIn.safetyInB;
    enabled = safety_output_a | safety_output_b;
    next_warnActive = warnNow;
    // any gap in the warning restarts the full delay
    warnExpire = warnNow && enabled && warnCnt == WARN_LIMIT - 35'd1;
    if (warnNow && enabled && !shutLatch) begin
      next_warnCnt = warnExpire ? warnCnt : warnCnt + 35'd1;
    end else begin
      next_warnCnt = '0;
    end
    // set beats clear in the same cycle
    next_shutLatch = shutLatch;
    if (!sIn.guardClosed && !warnNow) begin
      next_shutLatch = 1'b0;
    end
    if (warnExpire) begin
      next_shutLatch = 1'b1;
    end
    next_errLatch = errLatch;
    if (!sIn.guardClosed && !errNow) begin
      next_errLatch = 1'b0;
    end
    if (errNow) begin
      next_errLatch = 1'b1;
    end
    // only a power cycle (reset) ends the lock-out
    next_lockout = lockout | lockoutNow;
    next_forced = forced | sIn.forcedOpen;
    if (sIn.crossShort) begin
      curCode = CODE_CROSS;
    end else if (sIn.faultOutA) begin
      curCode = CODE_OUT_A;
    end else if (sIn.faultOutB) begin
      curCode = CODE_OUT_B;
    end else if (sIn.overTemp) begin
      curCode = CODE_TEMP;
    end else if (sIn.actuatorFault) begin
      curCode = CODE_ACTUATOR;
    end else if (sIn.internalErr) begin
      curCode = CODE_INTERNAL;
    end else if (sIn.lockMechErr) begin
      curCode = CODE_LOCK_MECH;
    end else if (sIn.voltFault) begin
      curCode = CODE_VOLT;
    end else begin
      curCode = CODE_NONE;
    end
    if (curCode != CODE_NONE) begin
      next_code = curCode;
    end else if (shutLatch || errLatch) begin
      next_code = code;
    end else begin
      next_code = CODE_NONE;
    end
    next_diag = sIn.guardClosed && (sIn.lockCmd || sIn.lockEngaged) &&
                !warnNow && !errNow && !shutLatch && !errLatch &&
                !lockout && !forced;
    next_leds.green = (bothIn && !forced) ? 1'b1 : blink;
    unique case (guard)
      GUARD_OPEN: next_leds.yellow = 1'b0;
      GUARD_CLOSED: next_leds.yellow = blink;
      GUARD_LOCKED: next_leds.yellow = 1'b1;
    endcase
    if (!bothIn) begin
      next_leds.red = 1'b0;
    end else if (sIn.deviceDefect) begin
      next_leds.red = 1'b1;
    end else begin
      next_leds.red = (code != CODE_NONE) && pulse;
    end
    if (forced) begin
      next_leds = '{green: blink, yellow: blink, red: blink};
    end
  end

  // ==========================================================
  // register bus and interrupts
  logic awHeld, wHeld, next_awHeld, next_wHeld;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData, next_rdata;
  logic wStrb0, next_wStrb0;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic next_variant, next_irq;
  logic [IRQ_W-1:0] irqStat, irqEn, next_irqStat, next_irqEn;
  logic [IRQ_W-1:0] irqClr, irqEv;
  logic [31:0] statusWord;

  always_comb begin
    statusWord = '0;
    statusWord[7:0] = {1'b0, forced, lockout, errLatch, shutLatch,
                       warnActive, safety_output_b, safety_output_a};
    statusWord[ST_CODE_LSB+:4] = code;
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb0 = wStrb0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_variant = variant;
    next_irqEn = irqEn;
    irqClr = '0;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_wData = wdata;
      next_wStrb0 = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (awHeld && wHeld && !bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (awAddr)
        REG_CTRL: if (wStrb0) next_variant = wData[CTRL_VARIANT];
        REG_IRQ_CLR: if (wStrb0) irqClr = wData[IRQ_W-1:0];
        REG_IRQ_EN: if (wStrb0) next_irqEn = wData[IRQ_W-1:0];
        REG_STATUS, REG_IRQ_STAT: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    next_awready = !next_awHeld;
    next_wready = !next_wHeld;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (araddr)
        REG_CTRL: next_rdata = 32'(variant);
        REG_STATUS: next_rdata = statusWord;
        REG_IRQ_STAT: next_rdata = 32'(irqStat);
        REG_IRQ_EN: next_rdata = 32'(irqEn);
        REG_IRQ_CLR: next_rdata = 32'h0000_0000;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
    irqEv = '0;
    irqEv[IRQ_WARN] = warnNow & ~warnActive;
    irqEv[IRQ_SHUT] = next_shutLatch & ~shutLatch;
    irqEv[IRQ_ERR] = next_errLatch & ~errLatch;
    irqEv[IRQ_FORCED] = next_forced & ~forced;
    irqEv[IRQ_LOCKOUT] = next_lockout & ~lockout;
    // a new event survives a clear in the same cycle
    next_irqStat = (irqStat & ~irqClr) | irqEv;
    next_irq = |(next_irqStat & next_irqEn);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      warnActive <= 1'b0;
      shutLatch <= 1'b0;
      errLatch <= 1'b0;
      lockout <= 1'b0;
      forced <= 1'b0;
      warnCnt <= '0;
      code <= CODE_NONE;
      lockEngage <= 1'b0;
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
      diagOut <= 1'b0;
      leds <= '0;
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb0 <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      variant <= CTRL_VARIANT_RESET;
      irqEn <= IRQ_EN_RESET;
      irqStat <= '0;
      irq <= 1'b0;
    end else begin
      warnActive <= next_warnActive;
      shutLatch <= next_shutLatch;
      errLatch <= next_errLatch;
      lockout <= next_lockout;
      forced <= next_forced;
      warnCnt <= next_warnCnt;
      code <= next_code;
      lockEngage <= next_lockEngage;
      safety_output_a <= next_outA;
      safety_output_b <= next_outB;
      diagOut <= next_diag;
      leds <= next_leds;
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb0 <= next_wStrb0;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      variant <= next_variant;
      irqEn <= next_irqEn;
      irqStat <= next_irqStat;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  lock_drive_a: assert property (sIn.lockCmd |=> !lockEngage)
    else $error("lock engaged while release commanded");
  unlock_off_a: assert property (!variant && !sIn.lockEngaged
    |=> !safety_output_a && !safety_output_b)
    else $error("outputs on while unlocked");
  open_off_a: assert property (!sIn.guardClosed
    |=> !safety_output_a && !safety_output_b)
    else $error("outputs on with guard open");
  warn_diag_a: assert property (warnNow |=> !diagOut)
    else $error("diagnostic high during warning");
  warn_timeout_a: assert property ($rose(shutLatch)
    |-> $past(warnCnt) == WARN_LIMIT - 35'd1)
    else $error("shutdown at wrong warning time");
  latch_hold_a: assert property (shutLatch && sIn.guardClosed
    |=> shutLatch)
    else $error("latched fault cleared with guard closed");
  warn_withdraw_a: assert property (!warnNow |=> !warnActive)
    else $error("warning not withdrawn");
  err_immediate_a: assert property (errNow
    |=> !safety_output_a && !safety_output_b)
    else $error("outputs on during internal error");
  green_steady_a: assert property (bothIn && !forced
    |=> leds.green)
    else $error("green not steady");
  red_quiet_a: assert property (!bothIn && !forced
    |=> !leds.red)
    else $error("red lit with input missing");
  forced_sync_a: assert property (forced |=> leds.green == leds.red
    && leds.red == leds.yellow && !diagOut)
    else $error("forced opening pattern wrong");
  lockout_hold_a: assert property (lockout |=> lockout
    && !safety_output_a)
    else $error("lock-out released");
  cover_enable_c: cover property (sIn.guardClosed && safety_output_a);
  cover_shut_c: cover property ($rose(shutLatch));
  cover_lockout_c: cover property ($rose(lockout));
endmodule : iss_top

//--- verification/iss_plc_model.sv
`timescale 1ns/1ps
// ==========================================================
// plc side plus bolt mechanics
module iss_plc_model
  import iss_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // requested levels and solenoid drive
  input iss_pins_t req,
  input wire logic boltDrive,
  input wire logic slow,
  // pins seen by the device
  output iss_pins_t pins
);
  int waitN;
  logic bolt;
  // bolt follows the drive only with the guard shut and drops when it opens; slow mode lags so the
  // device sees a drive that the mechanics have not followed yet
  always @(posedge sys_clk) begin
    if (reset || !req.guardClosed) begin
      bolt <= 1'b0;
      waitN <= 0;
    end else if (bolt != boltDrive) begin
      if (waitN >= (slow ? 6 : 0)) begin
        bolt <= boltDrive;
        waitN <= 0;
      end else begin
        waitN <= waitN + 1;
      end
    end
  end
  always_comb begin
    pins = req;
    pins.lockEngaged = bolt;
  end
endmodule : iss_plc_model

//--- verification/interlock_safety_supervisor_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module interlock_safety_supervisor_tb;
  import iss_pkg::*;
  localparam logic [34:0] WL = 35'h14;
  localparam int HC = 4;
  // ==========================================================
  // signals
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  iss_pins_t req = '0;
  iss_pins_t pins;
  logic lockEngage, safety_output_a, safety_output_b, diagOut, irq;
  iss_led_t leds;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int comparisons = 0;
  int variant = 0;
  int tg, ty, rr, ne;
  int codes[$] = '{4, 8};
  always #50 sys_clk = ~sys_clk;
  iss_top #(.WARN_LIMIT(WL), .HALF_CYCLES(HC)) dut (
    .sys_clk, .reset, .pins, .lockEngage, .safety_output_a,
    .safety_output_b, .diagOut, .leds, .irq,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready
  );
  iss_plc_model plc (
    .sys_clk, .reset, .req, .boltDrive(lockEngage), .slow, .pins
  );
  // ==========================================================
  // tasks
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 50) begin
        n_mismatch++;
        wrap_up();
      end
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 50) begin
        n_mismatch++;
        wrap_up();
      end
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  // two sync stages, the slow bolt lag and the output flop fit in 16
  task automatic settle;
    cyc(16);
  endtask : settle
  task automatic open_close;
    req.guardClosed <= 1'b0;
    settle();
    `CHK("open a", 1'b0, safety_output_a)
    `CHK("open b", 1'b0, safety_output_b)
    req.guardClosed <= 1'b1;
    settle();
  endtask : open_close
  // expected outputs from the variant and the steady pin levels
  task automatic chk_out;
    logic en;
    en = req.guardClosed && (variant == 1 || !req.lockCmd);
    `CHK("out a", en & req.safetyInA, safety_output_a)
    `CHK("out b", en & req.safetyInB, safety_output_b)
    `CHK("diag", req.guardClosed, diagOut)
  endtask : chk_out
  task automatic watch(input int n);
    iss_led_t p;
    tg = 0;
    ty = 0;
    rr = 0;
    ne = 0;
    p = leds;
    repeat (n) begin
      @(posedge sys_clk);
      if (leds.green !== p.green) tg++;
      if (leds.yellow !== p.yellow) ty++;
      if (leds.red === 1'b1 && p.red === 1'b0) rr++;
      if (!(leds.green === leds.yellow && leds.yellow === leds.red)) ne++;
      p = leds;
    end
  endtask : watch
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    int c;
    void'($urandom(32'he837_7452));
    req.safetyInA <= 1'b1;
    req.safetyInB <= 1'b1;
    req.actuatorOk <= 1'b1;
    req.lockCmd <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    cyc(3);
    rd(REG_CTRL, d);
    `CHK("ctrl reset", 32'h0, d)
    rd(REG_IRQ_EN, d);
    `CHK("irq en reset", 32'h0, d)
    rd(8'h40, d);
    `CHK("unmapped resp", RESP_SLVERR, resp)
    `CHK("unmapped data", 32'h0, d)
    wr(REG_STATUS, 32'hffff_ffff);
    `CHK("ro write resp", RESP_OKAY, resp)
    // slow bolt: the drive must not wait on the mechanics
    slow <= 1'b1;
    req.guardClosed <= 1'b1;
    settle();
    chk_out();
    req.lockCmd <= 1'b0;
    settle();
    `CHK("bolt lock", 1'b1, lockEngage)
    chk_out();
    req.lockCmd <= 1'b1;
    settle();
    `CHK("bolt release", 1'b0, lockEngage)
    chk_out();
    variant = 1;
    wr(REG_CTRL, 32'h1);
    settle();
    chk_out();
    open_close();
    chk_out();
    // warning, delayed shutdown, withdrawal, clearing by opening
    wr(REG_IRQ_EN, 32'h1f);
    c = codes[$urandom_range(1, 0)];
    if (c == 4) req.overTemp <= 1'b1;
    else req.voltFault <= 1'b1;
    cyc(4);
    `CHK("warn out a", 1'b1, safety_output_a)
    `CHK("warn diag", 1'b0, diagOut)
    cyc(25);
    `CHK("shut out a", 1'b0, safety_output_a)
    `CHK("shut out b", 1'b0, safety_output_b)
    `CHK("irq on", 1'b1, irq)
    rd(REG_STATUS, d);
    `CHK("code", c[3:0], d[11:8])
    watch(160);
    `CHK("red pulses", 2 * c, rr)
    wr(REG_IRQ_EN, 32'h0);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    req.overTemp <= 1'b0;
    req.voltFault <= 1'b0;
    settle();
    rd(REG_STATUS, d);
    `CHK("warn gone", 1'b0, d[2])
    `CHK("held off", 1'b0, safety_output_a)
    rd(REG_IRQ_STAT, d);
    `CHK("irq stat", 5'h03, d[4:0])
    wr(REG_IRQ_CLR, 32'h1f);
    rd(REG_IRQ_STAT, d);
    `CHK("irq cleared", 5'h00, d[4:0])
    wr(REG_IRQ_EN, 32'h1f);
    open_close();
    chk_out();
    // internal fault
    req.internalErr <= 1'b1;
    cyc(4);
    `CHK("err out a", 1'b0, safety_output_a)
    `CHK("err out b", 1'b0, safety_output_b)
    rd(REG_STATUS, d);
    `CHK("err latch", 1'b1, d[4])
    req.internalErr <= 1'b0;
    open_close();
    chk_out();
    // one safety input missing
    req.safetyInA <= 1'b0;
    settle();
    `CHK("no input a", 1'b0, safety_output_a)
    `CHK("keeps b", 1'b1, safety_output_b)
    watch(40);
    `CHK("green flash", 10, tg)
    `CHK("yellow closed", 10, ty)
    `CHK("red off", 1'b0, leds.red)
    req.lockCmd <= 1'b0;
    settle();
    watch(40);
    `CHK("yellow locked", 1'b1, leds.yellow)
    `CHK("yellow steady", 0, ty)
    req.lockCmd <= 1'b1;
    req.guardClosed <= 1'b0;
    settle();
    `CHK("yellow open", 1'b0, leds.yellow)
    req.safetyInA <= 1'b1;
    req.guardClosed <= 1'b1;
    settle();
    watch(40);
    `CHK("green steady", 0, tg)
    `CHK("green on", 1'b1, leds.green)
    // cross connection latches lock-out until power cycle
    req.crossShort <= 1'b1;
    settle();
    rd(REG_STATUS, d);
    `CHK("lock-out", 1'b1, d[5])
    req.crossShort <= 1'b0;
    open_close();
    `CHK("lock-out held", 1'b0, safety_output_b)
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    variant = 0;
    req.lockCmd <= 1'b0;
    settle();
    chk_out();
    // forced opening
    req.forcedOpen <= 1'b1;
    settle();
    watch(40);
    `CHK("leds in step", 0, ne)
    `CHK("leds flash", 1'b1, tg > 0)
    `CHK("forced a", 1'b0, safety_output_a)
    `CHK("forced diag", 1'b0, diagOut)
    wrap_up();
  end
endmodule : interlock_safety_supervisor_tb
